// ==== hdl/irq_wake_pkg.sv ====
// Purpose: shared constants and types for the interrupt gating and low-power wake block
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes: controller registers are reached over Avalon-MM with waitrequest
// How it works
// (RULE_01) six sources: two pins, three timers, serial
// (RULE_02) each source has its own enable bit
// (RULE_03) top bit zero blocks every interrupt
// (RULE_04) enable bits: ex0,t0,ex1,t1,ser,t2,reserved
// (RULE_05) software never writes one to bit six
// (RULE_06) timer two request ors overflow and event
// (RULE_07) vectoring leaves timer two flags set
// (RULE_08) timer0/1 flags set state5_phase2, polled next cycle
// (RULE_09) timer two flag set state2_phase2, polled same cycle
// (RULE_10) input clock halved before internal clocking
// (RULE_11) idle stops cpu, peripherals keep running
// (RULE_12) idle keeps ram and registers unchanged
// (RULE_13) enabled interrupt or reset ends idle
// (RULE_14) reset exit: two cycles, ram blocked, ports not
// (RULE_15) instruction after idle avoids port writes
// (RULE_16) power-down stops oscillator after final instruction
// (RULE_17) power-down held; exit by reset or external irq
// (RULE_18) reset exit reloads registers, keeps ram
// (RULE_19) reset held until oscillator restarts
// (RULE_20) strobes 1 in idle, 0 in power-down
// (RULE_21) request needs flag, enable and global enable
package irq_wake_pkg;
  // =====================================================
  // register map of the controller (word addresses)
  localparam logic [1:0] ADDR_ENABLE = 2'h0;
  localparam logic [1:0] ADDR_CONTROL = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_FLAGS = 2'h3;
  // =====================================================
  // enable register fields
  localparam int EN_EX0 = 0;
  localparam int EN_T0 = 1;
  localparam int EN_EX1 = 2;
  localparam int EN_T1 = 3;
  localparam int EN_SER = 4;
  localparam int EN_T2 = 5;
  localparam int EN_RSVD = 6;
  localparam int EN_GLOBAL = 7;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_WMASK = 8'hbf;
  // control register fields
  localparam int CTL_IDLE = 0;
  localparam int CTL_PDOWN = 1;
  localparam int CTL_EXTMEM = 2;
  // =====================================================
  // timing: twelve phases of two input clock periods per machine cycle, six states of two phases
  localparam int PHASES_PER_CYCLE = 12;
  localparam logic [3:0] PHASE_STATE2_PHASE2 = 4'h3;
  localparam logic [3:0] PHASE_STATE5_PHASE2 = 4'h9;
  localparam logic [3:0] PHASE_LAST = 4'hb;
  localparam int RESET_EXIT_CYCLES = 2;
  localparam int NUM_SRC = 6;
  // =====================================================
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PDOWN = 2'b10,
    MODE_RESET_EXIT = 2'b11
  } power_mode_t;
endpackage

// ==== hdl/irq_wake_if.sv ====
// Purpose: link between the interrupt controller and the cpu core end
// Assumes: both ends on core_clk_in
// Notes: no clocking block
interface irq_wake_if;
  logic [5:0] source_flag;
  logic [5:0] request;
  logic cpu_run;
  logic osc_run;
  logic ram_block;
  logic vector_ack;
  logic [2:0] vector_id;
  logic idle_cmd;
  logic pdown_cmd;
  logic clear_t2_ovf;
  logic clear_t2_evt;
  modport ctrl (
    input source_flag, vector_ack, vector_id, idle_cmd, pdown_cmd,
    output request, cpu_run, osc_run, ram_block
  );
  modport core (
    output source_flag, vector_ack, vector_id, idle_cmd, pdown_cmd,
    output clear_t2_ovf, clear_t2_evt,
    input request, cpu_run, osc_run, ram_block
  );
endinterface

// ==== hdl/phase_divider.sv ====
// Purpose: halves the input clock and counts the twelve phases of a machine cycle
// Assumes: run_in low freezes the counters, as the stopped oscillator would
// Notes: one clock only; every slower rate is an enable pulse
module phase_divider
  import irq_wake_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  output logic phase_en_out,
  output logic [3:0] phase_out,
  output logic cycle_end_out
);
  logic half_q;
  logic [3:0] phase_q;
  // =====================================================
  // halving removes any duty-cycle dependence
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      half_q <= 1'b0;
    end else if (run_in) begin
      half_q <= ~half_q; // RULE_10
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      phase_q <= 4'h0;
    end else if (run_in && half_q) begin
      phase_q <= (phase_q == PHASE_LAST) ? 4'h0 : phase_q + 4'h1;
    end
  end
  assign phase_en_out = run_in & half_q;
  assign phase_out = phase_q;
  assign cycle_end_out = run_in & half_q & (phase_q == PHASE_LAST);
endmodule

// ==== hdl/irq_wake_ctrl.sv ====
// Purpose: device end: interrupt gating, idle and power-down control, pin states
// Assumes: peripherals raise overflow pulses; the core end acknowledges vectors
// Notes: registers over Avalon-MM; answers one cycle after the request
module irq_wake_ctrl
  import irq_wake_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  irq_wake_if.ctrl link,
  input wire logic [1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic external_irq_zero_pin_in,
  input wire logic external_irq_one_pin_in,
  input wire logic timer0_ovf_in,
  input wire logic timer1_ovf_in,
  input wire logic timer2_ovf_in,
  input wire logic timer2_evt_in,
  input wire logic serial_flag_in,
  output logic address_latch_strobe_out,
  output logic program_fetch_strobe_out,
  output logic port0_oe_n_out,
  output logic port2_addr_sel_out,
  output logic [2:0] mode_out
);
  import irq_wake_pkg::*;
  logic [7:0] interrupt_enable_mask_q;
  logic ext_mem_q;
  power_mode_t mode_q;
  logic [1:0] exit_cnt_q;
  logic [1:0] ex0_sync_q, ex1_sync_q;
  logic timer_zero_overflow_flag_q, timer_one_overflow_flag_q;
  logic timer_two_overflow_flag_q, timer_two_event_flag_q;
  logic t0_pend_q, t1_pend_q, t2_pend_q;
  logic [5:0] flags;
  logic [5:0] gated;
  logic phase_en, cycle_end;
  logic [3:0] phase;
  logic req_q, wait_q;
  logic [31:0] rdata_q;
  logic [5:0] request_q;
  logic strobe_q, fetch_q, p0_oe_n_q, p2_sel_q;
  logic wr_en, rd_en;
  // =====================================================
  // clock phases; the oscillator stops in power-down
  phase_divider u_div (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .run_in(mode_q != MODE_PDOWN), // RULE_16
    .phase_en_out(phase_en),
    .phase_out(phase),
    .cycle_end_out(cycle_end)
  );
  // =====================================================
  // external pins cross into the clock domain
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ex0_sync_q <= 2'b00;
      ex1_sync_q <= 2'b00;
    end else begin
      ex0_sync_q <= {ex0_sync_q[0], external_irq_zero_pin_in};
      ex1_sync_q <= {ex1_sync_q[0], external_irq_one_pin_in};
    end
  end
  // =====================================================
  // timer 0/1 overflow is latched and posted at state5_phase2
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      t0_pend_q <= 1'b0;
      t1_pend_q <= 1'b0;
      timer_zero_overflow_flag_q <= 1'b0;
      timer_one_overflow_flag_q <= 1'b0;
    end else begin
      t0_pend_q <= (t0_pend_q | timer0_ovf_in) & ~(phase_en && phase == PHASE_STATE5_PHASE2);
      t1_pend_q <= (t1_pend_q | timer1_ovf_in) & ~(phase_en && phase == PHASE_STATE5_PHASE2);
      // the set wins over the vector acknowledge clearing the flag
      if (phase_en && phase == PHASE_STATE5_PHASE2 && (t0_pend_q | timer0_ovf_in)) begin
        timer_zero_overflow_flag_q <= 1'b1; // RULE_08
      end else if (link.vector_ack && link.vector_id == 3'(EN_T0)) begin
        timer_zero_overflow_flag_q <= 1'b0;
      end
      if (phase_en && phase == PHASE_STATE5_PHASE2 && (t1_pend_q | timer1_ovf_in)) begin
        timer_one_overflow_flag_q <= 1'b1; // RULE_08
      end else if (link.vector_ack && link.vector_id == 3'(EN_T1)) begin
        timer_one_overflow_flag_q <= 1'b0;
      end
    end
  end
  // timer 2 overflow posted at state2_phase2, event at once; only software clears them
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      t2_pend_q <= 1'b0;
      timer_two_overflow_flag_q <= 1'b0;
      timer_two_event_flag_q <= 1'b0;
    end else begin
      t2_pend_q <= (t2_pend_q | timer2_ovf_in) & ~(phase_en && phase == PHASE_STATE2_PHASE2);
      if (phase_en && phase == PHASE_STATE2_PHASE2 && (t2_pend_q | timer2_ovf_in)) begin
        timer_two_overflow_flag_q <= 1'b1; // RULE_09
      end else if (wr_en && avs_address_in == ADDR_FLAGS && avs_writedata_in[0]) begin
        timer_two_overflow_flag_q <= 1'b0; // RULE_07
      end
      if (timer2_evt_in) begin
        timer_two_event_flag_q <= 1'b1;
      end else if (wr_en && avs_address_in == ADDR_FLAGS && avs_writedata_in[1]) begin
        timer_two_event_flag_q <= 1'b0; // RULE_07
      end
    end
  end
  // =====================================================
  // source flags in enable-bit order
  always_comb begin
    flags = 6'h00;
    flags[EN_EX0] = ex0_sync_q[1] | link.source_flag[EN_EX0]; // RULE_01
    flags[EN_T0] = timer_zero_overflow_flag_q;
    flags[EN_EX1] = ex1_sync_q[1] | link.source_flag[EN_EX1];
    flags[EN_T1] = timer_one_overflow_flag_q;
    flags[EN_SER] = serial_flag_in | link.source_flag[EN_SER];
    flags[EN_T2] = timer_two_overflow_flag_q | timer_two_event_flag_q; // RULE_06
  end
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_gate
      // RULE_02 RULE_03 RULE_21
      assign gated[gi] = flags[gi] & interrupt_enable_mask_q[gi] &
                         interrupt_enable_mask_q[EN_GLOBAL];
    end
  endgenerate
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      request_q <= 6'h00;
    end else begin
      request_q <= gated; // RULE_21
    end
  end
  // =====================================================
  // avalon slave: one wait cycle, then answer
  assign wr_en = avs_write_in & ~wait_q & req_q;
  assign rd_en = avs_read_in & ~wait_q & req_q;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      req_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      req_q <= (avs_read_in | avs_write_in) & wait_q;
      wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
      if (avs_read_in && wait_q) begin
        if (avs_address_in == ADDR_ENABLE) begin
          rdata_q <= {24'h0, interrupt_enable_mask_q};
        end else if (avs_address_in == ADDR_CONTROL) begin
          rdata_q <= {29'h0, ext_mem_q, mode_q == MODE_PDOWN, mode_q == MODE_IDLE};
        end else if (avs_address_in == ADDR_STATUS) begin
          rdata_q <= {20'h0, phase, request_q, mode_q};
        end else begin
          rdata_q <= {30'h0, timer_two_event_flag_q, timer_two_overflow_flag_q};
        end
      end
    end
  end
  // registers hold in idle and power-down; only reset reloads them
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      interrupt_enable_mask_q <= ENABLE_RESET; // RULE_18
      ext_mem_q <= 1'b0;
    end else if (wr_en && avs_address_in == ADDR_ENABLE) begin
      interrupt_enable_mask_q <= avs_writedata_in[7:0] & ENABLE_WMASK; // RULE_04 RULE_05
    end else if (wr_en && avs_address_in == ADDR_CONTROL) begin
      ext_mem_q <= avs_writedata_in[CTL_EXTMEM];
    end
  end
  // =====================================================
  // power modes
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      // reset out of idle lets the core run briefly with ram blocked
      // a long reset must not lose the exit state taken at its first edge
      if (mode_q == MODE_IDLE || mode_q == MODE_RESET_EXIT) begin
        mode_q <= MODE_RESET_EXIT; // RULE_14
      end else begin
        mode_q <= MODE_RUN;
      end
      exit_cnt_q <= 2'(RESET_EXIT_CYCLES);
    end else begin
      case (mode_q)
        MODE_RUN: begin
          if (link.pdown_cmd || (wr_en && avs_address_in == ADDR_CONTROL &&
              avs_writedata_in[CTL_PDOWN])) begin
            mode_q <= MODE_PDOWN; // RULE_16
          end else if (link.idle_cmd || (wr_en && avs_address_in == ADDR_CONTROL &&
                       avs_writedata_in[CTL_IDLE])) begin
            mode_q <= MODE_IDLE; // RULE_11
          end
        end
        MODE_IDLE: begin
          if (|gated) begin
            mode_q <= MODE_RUN; // RULE_13
          end
        end
        MODE_PDOWN: begin
          if (gated[EN_EX0] || gated[EN_EX1]) begin
            mode_q <= MODE_RUN; // RULE_17
          end
        end
        MODE_RESET_EXIT: begin
          if (cycle_end) begin
            if (exit_cnt_q == 2'h1) begin
              mode_q <= MODE_RUN;
            end
            exit_cnt_q <= exit_cnt_q - 2'h1; // RULE_14
          end
        end
        default: mode_q <= MODE_RUN;
      endcase
    end
  end
  // =====================================================
  // pin states by mode
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      strobe_q <= 1'b1;
      fetch_q <= 1'b1;
      p0_oe_n_q <= 1'b0;
      p2_sel_q <= 1'b0;
    end else begin
      strobe_q <= (mode_q != MODE_PDOWN); // RULE_20
      fetch_q <= (mode_q != MODE_PDOWN); // RULE_20
      p0_oe_n_q <= ext_mem_q && (mode_q == MODE_IDLE || mode_q == MODE_PDOWN);
      p2_sel_q <= ext_mem_q && (mode_q != MODE_PDOWN);
    end
  end
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign address_latch_strobe_out = strobe_q;
  assign program_fetch_strobe_out = fetch_q;
  assign port0_oe_n_out = p0_oe_n_q;
  assign port2_addr_sel_out = p2_sel_q;
  assign mode_out = {1'b0, mode_q};
  assign link.request = request_q;
  // idle stops only the cpu; ram and registers stay as they are
  assign link.cpu_run = (mode_q == MODE_RUN) || (mode_q == MODE_RESET_EXIT); // RULE_12
  assign link.osc_run = (mode_q != MODE_PDOWN);
  assign link.ram_block = (mode_q == MODE_RESET_EXIT); // RULE_14
endmodule

// ==== hdl/irq_wake_core.sv ====
// Purpose: cpu-core end: takes requests, vectors, commands idle and power-down
// Assumes: fixed priority by enable-bit order
// Notes: user side is plain ports
module irq_wake_core
  import irq_wake_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  irq_wake_if.core link,
  input wire logic [5:0] user_flag_in,
  input wire logic idle_req_in,
  input wire logic pdown_req_in,
  output logic vector_valid_out,
  output logic [2:0] vector_id_out,
  output logic running_out
);
  import irq_wake_pkg::*;
  logic ack_q;
  logic [2:0] id_q;
  logic idle_q, pdown_q, run_q;
  logic [2:0] pick;
  // =====================================================
  always_comb begin
    pick = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (link.request[i]) begin
        pick = 3'(i);
      end
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
      id_q <= 3'h0;
      idle_q <= 1'b0;
      pdown_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      // acknowledging leaves timer two flags for software to clear
      ack_q <= link.cpu_run && (|link.request) && !ack_q; // RULE_07
      id_q <= pick;
      // software avoids port writes right after idle; one command per request
      idle_q <= idle_req_in && link.cpu_run && !idle_q; // RULE_15
      pdown_q <= pdown_req_in && link.cpu_run && !pdown_q;
      run_q <= link.cpu_run;
    end
  end
  assign link.source_flag = user_flag_in;
  assign link.vector_ack = ack_q;
  assign link.vector_id = id_q;
  assign link.idle_cmd = idle_q;
  assign link.pdown_cmd = pdown_q;
  assign link.clear_t2_ovf = 1'b0;
  assign link.clear_t2_evt = 1'b0;
  assign vector_valid_out = ack_q;
  assign vector_id_out = id_q;
  assign running_out = run_q;
endmodule

// ==== sim/irq_wake_props.sv ====
// Purpose: concurrent checks on the link between the controller and the core end
// Assumes: one clock, synchronous active-high reset
// Notes: sees only link signals; register behaviour is judged by the bench
module irq_wake_props (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [5:0] request,
  input wire logic cpu_run,
  input wire logic osc_run,
  input wire logic ram_block,
  input wire logic vector_ack,
  input wire logic idle_cmd,
  input wire logic pdown_cmd,
  input wire logic clear_t2_ovf,
  input wire logic clear_t2_evt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========
  // helpers
  logic [7:0] block_cnt_q;
  logic ext_req;
  assign ext_req = request[0] | request[2];
  // saturates so a stuck block cannot wrap back under the limit
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !ram_block) begin
      block_cnt_q <= 8'h00;
    end else if (block_cnt_q != 8'hff) begin
      block_cnt_q <= block_cnt_q + 8'h01;
    end
  end
  sequence idle_s;
    osc_run && !cpu_run && !ram_block;
  endsequence
  sequence quiet_s;
    request == 6'h00;
  endsequence
  // ==========
  // properties
  stop_order_a: assert property (!osc_run |-> !cpu_run)
    else $error("cpu runs with oscillator stopped");
  block_limit_a: assert property (ram_block |-> block_cnt_q < 8'h30)
    else $error("ram block longer than two machine cycles");
  idle_entry_a: assert property ((idle_cmd && cpu_run) ##0 quiet_s |-> ##[1:4] (!cpu_run || request != 6'h00))
    else $error("idle command did not stop cpu");
  idle_wake_a: assert property (idle_s ##0 (request != 6'h00) |-> ##[0:4] cpu_run)
    else $error("enabled request did not end idle");
  idle_hold_a: assert property (idle_s |=> (!cpu_run || request != 6'h00))
    else $error("idle left without a request");
  pdown_entry_a: assert property ((pdown_cmd && cpu_run && !ext_req) |-> ##[1:4] !osc_run)
    else $error("power-down command did not stop oscillator");
  pdown_wake_a: assert property (!osc_run ##1 osc_run |-> ext_req || $past(ext_req) || $past(ext_req, 2))
    else $error("power-down left without external request");
  no_t2_clear_a: assert property (vector_ack |-> !clear_t2_ovf && !clear_t2_evt)
    else $error("vectoring cleared a timer two flag");
  ack_cause_a: assert property (vector_ack |-> $past(request) != 6'h00 || $past(request, 2) != 6'h00)
    else $error("vector taken with no gated request");
endmodule

// ==== sim/irq_enable_and_power_wake_tb.sv ====
// Purpose: self-checking bench for the controller and core end joined by the link
// Assumes: 10 MHz clock, reset held 10 cycles
// Notes: reads are scored from a queue by a watcher process
module irq_enable_and_power_wake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_wake_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] adr = 2'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [5:0] src = 6'h00;
  logic t2evt = 1'b0;
  logic ale, pfs, p0oen, p2sel, vvalid, running, seen;
  logic [2:0] mode, vid;
  logic [2:0] vid_seen = 3'h7;
  logic [5:0] uflag = 6'h00;
  logic idle_rq = 1'b0;
  logic pd_rq = 1'b0;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  always #50 clk = ~clk;
  // ==========
  // design
  irq_wake_if irq_wake_if_inst ();
  irq_wake_ctrl irq_wake_ctrl_inst (.core_clk_in(clk), .sys_rst_in(rst),
    .link(irq_wake_if_inst), .avs_address_in(adr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .external_irq_zero_pin_in(src[0]),
    .external_irq_one_pin_in(src[2]), .timer0_ovf_in(src[1]), .timer1_ovf_in(src[3]),
    .timer2_ovf_in(src[5]), .timer2_evt_in(t2evt), .serial_flag_in(src[4]),
    .address_latch_strobe_out(ale), .program_fetch_strobe_out(pfs),
    .port0_oe_n_out(p0oen), .port2_addr_sel_out(p2sel), .mode_out(mode));
  irq_wake_core irq_wake_core_inst (.core_clk_in(clk), .sys_rst_in(rst),
    .link(irq_wake_if_inst), .user_flag_in(uflag), .idle_req_in(idle_rq),
    .pdown_req_in(pd_rq), .vector_valid_out(vvalid), .vector_id_out(vid),
    .running_out(running));
  irq_wake_props irq_wake_props_inst (.core_clk_in(clk), .sys_rst_in(rst),
    .request(irq_wake_if_inst.request), .cpu_run(irq_wake_if_inst.cpu_run),
    .osc_run(irq_wake_if_inst.osc_run), .ram_block(irq_wake_if_inst.ram_block),
    .vector_ack(irq_wake_if_inst.vector_ack), .idle_cmd(irq_wake_if_inst.idle_cmd),
    .pdown_cmd(irq_wake_if_inst.pdown_cmd),
    .clear_t2_ovf(irq_wake_if_inst.clear_t2_ovf),
    .clear_t2_evt(irq_wake_if_inst.clear_t2_evt));
  // ==========
  // tasks
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (exp_q.size() != 0) miscompares++;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // request and its qualifiers held until waitrequest is sampled low
  task automatic xfer(logic wr, logic [1:0] a, logic [31:0] d);
    adr <= a;
    wdat <= d;
    rd_en <= ~wr;
    wr_en <= wr;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [1:0] a, logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic pulse(int i);
    src <= 6'h01 << i;
    @(posedge clk);
    src <= 6'h00;
  endtask
  task automatic watch(int i, int cnt);
    seen = 1'b0;
    repeat (cnt) begin
      @(posedge clk);
      seen = seen | irq_wake_if_inst.request[i];
    end
  endtask
  task automatic wait_mode(logic [2:0] e);
    n = 0;
    while (mode !== e && n < 200) begin
      n++;
      @(posedge clk);
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // ==========
  // watchers
  always @(posedge clk) begin
    if (rd_en && wreq === 1'b0 && exp_q.size() != 0) chk("readdata", exp_q.pop_front(), rdat);
  end
  always @(posedge clk) begin
    if (vvalid === 1'b1) vid_seen <= vid;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // ==========
  // tests
  initial begin
    void'($urandom(32'h1c00776c));
    do_reset();
    chk("ale", 32'h1, 32'(ale));
    chk("mode", 32'h0, 32'(mode));
    rd(ADDR_ENABLE, 32'(ENABLE_RESET));
    xfer(1'b1, ADDR_ENABLE, 32'hff);
    rd(ADDR_ENABLE, 32'hbf);
    wdat <= 32'($urandom) & 32'hbf;
    @(posedge clk);
    xfer(1'b1, ADDR_ENABLE, wdat);
    rd(ADDR_ENABLE, wdat);
    $display("register test done");
    for (int i = 0; i < 6; i++) begin
      uflag <= 6'($urandom);
      xfer(1'b1, ADDR_ENABLE, 32'h1 << i);
      pulse(i);
      watch(i, 40);
      chk("req_off", 32'h0, 32'(seen));
      xfer(1'b1, ADDR_ENABLE, 32'h80 | (32'h1 << i));
      pulse(i);
      watch(i, 60);
      chk("req_on", 32'h1, 32'(seen));
    end
    uflag <= 6'h00;
    watch(5, 20);
    chk("t2_kept", 32'h1, 32'(irq_wake_if_inst.request[5]));
    rd(ADDR_FLAGS, 32'h1);
    xfer(1'b1, ADDR_FLAGS, 32'h1);
    t2evt <= 1'b1;
    @(posedge clk);
    t2evt <= 1'b0;
    watch(5, 20);
    chk("t2_evt", 32'h1, 32'(irq_wake_if_inst.request[5]));
    xfer(1'b1, ADDR_FLAGS, 32'h3);
    rd(ADDR_FLAGS, 32'h0);
    xfer(1'b1, ADDR_ENABLE, 32'h81);
    $display("gating test done");
    xfer(1'b1, ADDR_CONTROL, 32'h4);
    idle_rq <= 1'b1;
    wait_mode(3'h1);
    idle_rq <= 1'b0;
    chk("mode", 32'h1, 32'(mode));
    @(posedge clk);
    chk("pins", 32'hf, {28'h0, ale, pfs, p0oen, p2sel});
    chk("running", 32'h0, 32'(running));
    rd(ADDR_ENABLE, 32'h81);
    rd(ADDR_CONTROL, 32'h5);
    pulse(3);
    watch(0, 40);
    chk("mode", 32'h1, 32'(mode));
    pulse(0);
    wait_mode(3'h0);
    chk("mode", 32'h0, 32'(mode));
    repeat (2) @(posedge clk);
    chk("vector_id", 32'h0, 32'(vid_seen));
    xfer(1'b1, ADDR_CONTROL, 32'h5);
    wait_mode(3'h1);
    chk("mode", 32'h1, 32'(mode));
    pulse(0);
    wait_mode(3'h0);
    chk("mode", 32'h0, 32'(mode));
    $display("idle test done");
    xfer(1'b1, ADDR_ENABLE, 32'h91);
    pd_rq <= 1'b1;
    wait_mode(3'h2);
    pd_rq <= 1'b0;
    @(posedge clk);
    chk("pins", 32'h2, {28'h0, ale, pfs, p0oen, p2sel});
    rd(ADDR_ENABLE, 32'h91);
    pulse(4);
    watch(0, 40);
    chk("mode", 32'h2, 32'(mode));
    pulse(0);
    wait_mode(3'h0);
    chk("mode", 32'h0, 32'(mode));
    pd_rq <= 1'b1;
    wait_mode(3'h2);
    pd_rq <= 1'b0;
    do_reset();
    rd(ADDR_ENABLE, 32'h0);
    $display("power-down test done");
    idle_rq <= 1'b1;
    wait_mode(3'h1);
    idle_rq <= 1'b0;
    do_reset();
    chk("mode", 32'h3, 32'(mode));
    chk("ram_block", 32'h1, 32'(irq_wake_if_inst.ram_block));
    wait_mode(3'h0);
    chk("exit_len", 32'h1, 32'(n <= 48));
    $display("reset exit test done");
    complete_run();
  end
endmodule
